// >>> rtl/arinc_tx_device.sv
// ARINC 429 transmitter device end: FIFO, serializer, parity, self-test loopback
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "arinc_tx_consts.svh"
module arinc_tx_device (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  // Pin link
  arinc_tx_if.dev bus,
  // Status
  output logic [3:0] FIFO_LEVEL_O
);

  arinc_tx_pkg::dev_state_t q;
  arinc_tx_pkg::dev_state_t d;

  // ========================================================================
  // Word assembly from the two bus images
  function automatic logic [31:0] assemble(input logic [15:0] b1, input logic [15:0] b2);
    logic [31:0] a;
    a = 32'h0;
    for (int k = 0; k < 8; k++) begin
      a[k] = b1[7 - k];
    end
    a[12:8] = b1[15:11];
    a[28:13] = b2;
    // Bits 30, 31 and 32 ride in the middle of the first byte
    a[29] = b1[9];
    a[30] = b1[10];
    a[31] = b1[8];
    return a;
  endfunction : assemble

  // Bit 32 chosen from the settings in force when the word leaves the FIFO
  function automatic logic [31:0] with_bit32(input logic [31:0] w, input logic insert,
                                             input logic even, input logic ctl_n);
    logic [31:0] r;
    r = w;
    if (ctl_n || insert) begin
      r[31] = even ? (^w[30:0]) : ~(^w[30:0]);
    end
    return r;
  endfunction : with_bit32

  // A write and a read in one cycle leave the word count unchanged
  logic push;
  logic pop;
  logic [8:0] half;
  logic [8:0] gap;

  // ========================================================================
  // Next state
  always_comb begin
    d = q;
    push = 1'b0;
    pop = 1'b0;
    half = q.rate_slow ? `HALF_BIT_LS : `HALF_BIT_HS;
    gap = q.rate_slow ? `WORD_GAP_LS : `WORD_GAP_HS;

    // ======================================================================
    // Strobe images, so each pin edge is seen from one registered copy
    d.load1_n_prev = bus.first_byte_load_strobe_n;
    d.load2_n_prev = bus.second_byte_load_strobe_n;
    d.cw_prev = bus.control_word_strobe;

    // ======================================================================
    // FIFO write side
    // Strobes take the bus on their trailing (rising) edge; a strobe that
    // never stands low across a clock edge is missed
    if (!q.load1_n_prev && bus.first_byte_load_strobe_n) begin
      d.byte1 = bus.bd;
      d.byte1_ok = 1'b1;
    end
    // A second byte with no first byte since the last word is dropped, so a
    // stray strobe cannot queue half a word
    if (!q.load2_n_prev && bus.second_byte_load_strobe_n) begin
      d.byte1_ok = 1'b0;
      push = q.byte1_ok && (q.count < `FIFO_DEPTH);
    end
    if (push) begin
      d.mem[q.wr_ptr] = assemble(q.byte1, bus.bd);
      d.wr_ptr = q.wr_ptr + 3'h1;
    end

    // ======================================================================
    // Control word register
    if (!q.cw_prev && bus.control_word_strobe) begin
      d.parity_insert = bus.bd[`CW_PARITY_INSERT];
      d.loopback_test_n = bus.bd[`CW_LOOPBACK_TEST];
      d.parity_even = bus.bd[`CW_PARITY_SENSE];
      d.rate_slow = bus.bd[`CW_RATE_SELECT];
    end

    // ======================================================================
    // Serializer
    unique case (q.state)
      arinc_tx_pkg::TX_IDLE: begin
        if (bus.transmit_enable_input && (q.count != 4'h0)) begin
          pop = 1'b1;
          d.shreg = with_bit32(q.mem[q.rd_ptr], q.parity_insert, q.parity_even,
                               bus.bit32_control_enable_n);
          d.rd_ptr = q.rd_ptr + 3'h1;
          d.bit_idx = 5'h0;
          d.timer = half - 9'h1;
          d.state = arinc_tx_pkg::TX_DATA;
        end
      end
      arinc_tx_pkg::TX_DATA: begin
        if (q.timer == 9'h0) begin
          d.timer = half - 9'h1;
          d.state = arinc_tx_pkg::TX_NULL;
        end else begin
          d.timer = q.timer - 9'h1;
        end
      end
      arinc_tx_pkg::TX_NULL: begin
        if (q.timer != 9'h0) begin
          d.timer = q.timer - 9'h1;
        end else if (q.bit_idx == `LAST_BIT_IDX) begin
          // The gap follows every word, so a word loaded just after the FIFO
          // ran dry still waits out the full null time
          d.timer = gap - 9'h2;
          d.state = arinc_tx_pkg::TX_GAP;
        end else begin
          d.bit_idx = q.bit_idx + 5'h1;
          d.shreg = {1'b0, q.shreg[31:1]};
          d.timer = half - 9'h1;
          d.state = arinc_tx_pkg::TX_DATA;
        end
      end
      arinc_tx_pkg::TX_GAP: begin
        // One idle cycle follows, which completes the gap count
        if (q.timer == 9'h0) begin
          d.state = arinc_tx_pkg::TX_IDLE;
        end else begin
          d.timer = q.timer - 9'h1;
        end
      end
    endcase

    // ======================================================================
    // Word counter and pin images
    d.count = q.count + {3'h0, push} - {3'h0, pop};
    d.ones = (d.state == arinc_tx_pkg::TX_DATA) && d.shreg[0];
    d.zeroes = (d.state == arinc_tx_pkg::TX_DATA) && !d.shreg[0];
    // Ready is already high in the gap after the last word has gone
    d.ready = (d.count == 4'h0) &&
              ((d.state == arinc_tx_pkg::TX_IDLE) || (d.state == arinc_tx_pkg::TX_GAP));
    d.loop_ones = !d.loopback_test_n && d.ones;
    d.loop_zeroes = !d.loopback_test_n && d.zeroes;

    // ======================================================================
    // Data clock divider; it runs free, outside words too, as a steady rate
    if (q.div >= half - 9'h1) begin
      d.div = 9'h0;
      d.tx_clk = !q.tx_clk;
    end else begin
      d.div = q.div + 9'h1;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      // Link left idle: load strobe images high, control strobe image low, self-test off, ready high
      q <= '0;
      q.load1_n_prev <= 1'b1;
      q.load2_n_prev <= 1'b1;
      q.loopback_test_n <= 1'b1;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.transmit_ready = q.ready;
  assign bus.serial_ones_output = q.ones;
  assign bus.serial_zeroes_output = q.zeroes;
  assign bus.tx_clk = q.tx_clk;
  assign bus.loop_ones = q.loop_ones;
  assign bus.loop_zeroes = q.loop_zeroes;
  assign FIFO_LEVEL_O = q.count;

endmodule : arinc_tx_device
`default_nettype wire

// >>> rtl/arinc_tx_consts.svh
// Constants shared by the transmitter device end and the host controller end
`ifndef ARINC_TX_CONSTS_SVH
`define ARINC_TX_CONSTS_SVH

// ==========================================================================
// FIFO and word shape
`define FIFO_DEPTH 4'h8
`define WORD_BITS 32
`define LAST_BIT_IDX 5'h1f

// ==========================================================================
// Bit timing in master clocks
`define HALF_BIT_HS 9'h005
`define HALF_BIT_LS 9'h028
`define WORD_GAP_HS 9'h028
`define WORD_GAP_LS 9'h140

// ==========================================================================
// Control word bit positions on the data bus
`define CW_PARITY_INSERT 4
`define CW_LOOPBACK_TEST 5
`define CW_PARITY_SENSE 12
`define CW_RATE_SELECT 13

// ==========================================================================
// Host register offsets
`define HOST_WORD_LO 4'h0
`define HOST_WORD_HI 4'h4
`define HOST_CONTROL 4'h8
`define HOST_TX_CTRL 4'hc
`define HOST_STATUS 4'h0

// Host tx control bits
`define TXC_ENABLE 0
`define TXC_BIT32_CTL 1
`define TXC_RESET 2'h2

`endif

// >>> rtl/arinc_tx_pkg.sv
// Types for the transmitter device end and the host controller end
package arinc_tx_pkg;

  // ========================================================================
  // Device end
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_NULL = 2'b10,
    TX_GAP = 2'b11
  } tx_state_t;

  typedef struct packed {
    logic [7:0][31:0] mem;
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [3:0] count;
    logic [15:0] byte1;
    logic byte1_ok;
    logic load1_n_prev;
    logic load2_n_prev;
    logic cw_prev;
    logic parity_insert;
    logic loopback_test_n;
    logic parity_even;
    logic rate_slow;
    tx_state_t state;
    logic [31:0] shreg;
    logic [4:0] bit_idx;
    logic [8:0] timer;
    logic [8:0] div;
    logic tx_clk;
    logic ones;
    logic zeroes;
    logic ready;
    logic loop_ones;
    logic loop_zeroes;
  } dev_state_t;

  // ========================================================================
  // Host end
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOAD1 = 3'b001,
    H_HOLD1 = 3'b010,
    H_LOAD2 = 3'b011,
    H_HOLD2 = 3'b100,
    H_CW = 3'b101,
    H_HOLDCW = 3'b110
  } host_state_t;

  typedef struct packed {
    host_state_t state;
    logic [15:0] word_lo;
    logic [15:0] word_hi;
    logic [15:0] cw;
    logic [15:0] bd;
    logic load1_n;
    logic load2_n;
    logic cw_strobe;
    logic en_req;
    logic tx_enable;
    logic bit32_ctl;
    logic [31:0] rdata;
  } host_state_s_t;

endpackage : arinc_tx_pkg

// >>> rtl/arinc_tx_if.sv
// Pin-level link between the host controller and the transmitter device
`timescale 1ns/100ps
`default_nettype none
interface arinc_tx_if;
  logic [15:0] bd;
  logic first_byte_load_strobe_n;
  logic second_byte_load_strobe_n;
  logic control_word_strobe;
  logic transmit_enable_input;
  logic bit32_control_enable_n;
  logic transmit_ready;
  logic serial_ones_output;
  logic serial_zeroes_output;
  logic tx_clk;
  logic loop_ones;
  logic loop_zeroes;

  modport dev (
    input bd, first_byte_load_strobe_n, second_byte_load_strobe_n, control_word_strobe,
    input transmit_enable_input, bit32_control_enable_n,
    output transmit_ready, serial_ones_output, serial_zeroes_output, tx_clk, loop_ones, loop_zeroes
  );

  modport host (
    output bd, first_byte_load_strobe_n, second_byte_load_strobe_n, control_word_strobe,
    output transmit_enable_input, bit32_control_enable_n,
    input transmit_ready, serial_ones_output, serial_zeroes_output, tx_clk, loop_ones, loop_zeroes
  );
endinterface : arinc_tx_if
`default_nettype wire

// >>> rtl/arinc_tx_host.sv
// Host controller end: register port to strobe sequences on the transmitter pins
`include "arinc_tx_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module arinc_tx_host (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Pin link
  arinc_tx_if.host bus
);

  arinc_tx_pkg::host_state_s_t q;
  arinc_tx_pkg::host_state_s_t d;
  logic idle;

  // ========================================================================
  // Next state
  always_comb begin
    d = q;
    idle = (q.state == arinc_tx_pkg::H_IDLE);
    d.rdata = 32'h0;
    if (RD_I && ADDR_I == `HOST_STATUS) begin
      d.rdata = {28'h0, q.bit32_ctl, q.tx_enable, !idle, bus.transmit_ready};
    end
    // Every write that arrives while a sequence runs is dropped, whatever its address
    if (WR_I && idle) begin
      unique case (ADDR_I)
        `HOST_WORD_LO: d.word_lo = WDATA_I[15:0];
        `HOST_WORD_HI: begin
          d.word_hi = WDATA_I[15:0];
          d.state = arinc_tx_pkg::H_LOAD1;
        end
        `HOST_CONTROL: begin
          d.cw = WDATA_I[15:0];
          d.state = arinc_tx_pkg::H_CW;
        end
        `HOST_TX_CTRL: begin
          d.en_req = WDATA_I[`TXC_ENABLE];
          d.bit32_ctl = WDATA_I[`TXC_BIT32_CTL];
        end
        default: ;
      endcase
    end

    d.load1_n = 1'b1;
    d.load2_n = 1'b1;
    d.cw_strobe = 1'b0;
    unique case (q.state)
      arinc_tx_pkg::H_IDLE: ;
      arinc_tx_pkg::H_LOAD1: begin
        d.bd = q.word_lo;
        d.load1_n = 1'b0;
        d.state = arinc_tx_pkg::H_HOLD1;
      end
      arinc_tx_pkg::H_HOLD1: d.state = arinc_tx_pkg::H_LOAD2;
      arinc_tx_pkg::H_LOAD2: begin
        d.bd = q.word_hi;
        d.load2_n = 1'b0;
        d.state = arinc_tx_pkg::H_HOLD2;
      end
      arinc_tx_pkg::H_HOLD2: d.state = arinc_tx_pkg::H_IDLE;
      arinc_tx_pkg::H_CW: begin
        d.bd = q.cw;
        d.cw_strobe = 1'b1;
        d.state = arinc_tx_pkg::H_HOLDCW;
      end
      arinc_tx_pkg::H_HOLDCW: d.state = arinc_tx_pkg::H_IDLE;
      default: d.state = arinc_tx_pkg::H_IDLE;
    endcase

    // Enable may only fall once the device reports ready
    if (d.en_req) begin
      d.tx_enable = 1'b1;
    end else if (bus.transmit_ready) begin
      d.tx_enable = 1'b0;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      q <= '0;
      q.load1_n <= 1'b1;
      q.load2_n <= 1'b1;
      q.bit32_ctl <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.bd = q.bd;
  assign bus.first_byte_load_strobe_n = q.load1_n;
  assign bus.second_byte_load_strobe_n = q.load2_n;
  assign bus.control_word_strobe = q.cw_strobe;
  assign bus.transmit_enable_input = q.tx_enable;
  assign bus.bit32_control_enable_n = q.bit32_ctl;
  assign RDATA_O = q.rdata;

endmodule : arinc_tx_host
`default_nettype wire

// >>> bench/arinc_tx_chk.sv
// Assertions on the pin link between the host controller and the transmitter device
`timescale 1ns/100ps
`default_nettype none
module arinc_tx_chk (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  // Link
  input wire logic [15:0] bd,
  input wire logic second_byte_load_strobe_n,
  input wire logic control_word_strobe,
  input wire logic transmit_enable_input,
  input wire logic transmit_ready,
  input wire logic serial_ones_output,
  input wire logic serial_zeroes_output,
  input wire logic loop_ones,
  input wire logic loop_zeroes,
  input wire logic tx_clk
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  logic act;
  logic self_off_q;
  assign act = serial_ones_output | serial_zeroes_output;
  // ====================
  // Mirror of the loopback bit, so the copies can be judged from outside
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      self_off_q <= 1'b1;
    end else if (control_word_strobe) begin
      self_off_q <= bd[5];
    end
  end
  // ====================
  // Properties
  a_outputs_exclusive: assert property (!(serial_ones_output && serial_zeroes_output))
    else $error("ones and zeroes outputs active together");
  a_reset_idle: assert property ($rose(RESETN_I) |-> transmit_ready && !act)
    else $error("link not idle after reset");
  a_start_in_time: assert property ($rose(transmit_enable_input) && !transmit_ready |-> ##[1:200] act)
    else $error("first bit late after enable");
  a_data_half: assert property ($rose(act) |-> act [*5])
    else $error("data half too short");
  a_null_half: assert property ($fell(act) |-> !act [*5])
    else $error("null half too short");
  a_ready_on_load: assert property ($rose(second_byte_load_strobe_n) |-> ##[1:2] !transmit_ready)
    else $error("ready not low after load");
  a_idle_null: assert property (transmit_ready |-> !act)
    else $error("output active while ready");
  a_loop_copy: assert property (!self_off_q && !$past(self_off_q, 3) |->
    (loop_ones == serial_ones_output || loop_ones == $past(serial_ones_output)) &&
    (loop_zeroes == serial_zeroes_output || loop_zeroes == $past(serial_zeroes_output)))
    else $error("loopback copy wrong");
  a_loop_quiet: assert property (self_off_q && $past(self_off_q, 3) |-> !loop_ones && !loop_zeroes)
    else $error("loopback active while off");
  a_txclk_half: assert property ($changed(tx_clk) |=> $stable(tx_clk) [*4])
    else $error("data clock half period too short");
  c_ready_rise: cover property ($rose(transmit_ready));
  c_loop_seen: cover property (loop_ones);
  c_bit_pair: cover property ($fell(act) ##5 act);
endmodule : arinc_tx_chk
`default_nettype wire

// >>> bench/arinc429_transmitter_fifo_bench.sv
// Testbench joining host controller and transmitter device over the pin link
`timescale 1ns/100ps
`default_nettype none
module arinc429_transmitter_fifo_bench;
  logic clk_sys;
  logic resetn;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [3:0] level;
  logic act;
  logic [31:0] w;
  logic [31:0] s;
  int n;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  arinc_tx_if bus ();
  assign act = bus.serial_ones_output | bus.serial_zeroes_output;
  arinc_tx_device u_arinc_tx_device (.CLK_SYS_I(clk_sys), .RESETN_I(resetn), .bus(bus), .FIFO_LEVEL_O(level));
  arinc_tx_host u_arinc_tx_host (.CLK_SYS_I(clk_sys), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .bus(bus));
  arinc_tx_chk u_arinc_tx_chk (.CLK_SYS_I(clk_sys), .RESETN_I(resetn), .bd(bus.bd),
    .second_byte_load_strobe_n(bus.second_byte_load_strobe_n), .control_word_strobe(bus.control_word_strobe),
    .transmit_enable_input(bus.transmit_enable_input), .transmit_ready(bus.transmit_ready),
    .serial_ones_output(bus.serial_ones_output), .serial_zeroes_output(bus.serial_zeroes_output),
    .loop_ones(bus.loop_ones), .loop_zeroes(bus.loop_zeroes), .tx_clk(bus.tx_clk));
  // ====================
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input int pause);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(pause);
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    d = rdata;
    tick(1);
  endtask : rd_reg
  // Byte lanes as the bus carries them; the host is busy for 4 cycles after the upper byte
  task automatic load(input logic [31:0] a);
    wr_reg(4'h0, {16'h0, a[12:8], a[30], a[29], a[31], a[0], a[1], a[2], a[3], a[4], a[5], a[6], a[7]}, 1);
    wr_reg(4'h4, {16'h0, a[28:13]}, 5);
  endtask : load
  function automatic logic [31:0] expw(input logic [31:0] a, input int m);
    expw = {(m == 2) ? a[31] : (^a[30:0] ^ (m == 0)), a[30:0]};
  endfunction : expw
  // Samples each bit at its first cycle and the edges of its data half
  task automatic rx(input int half, input logic [31:0] a, input int m);
    logic [31:0] hi;
    logic [31:0] lo;
    n = 0;
    while (!act && n < 4000) begin
      tick(1);
      n++;
    end
    for (int i = 0; i < 32; i++) begin
      w[i] = bus.serial_ones_output;
      tick(half - 1);
      hi[i] = act;
      tick(1);
      lo[i] = act;
      tick(half);
    end
    chk("serial word", w, expw(a, m));
    chk("data halves", hi, 32'hffffffff);
    chk("null halves", lo, 32'h0);
  endtask : rx
  // ====================
  // Scenarios
  task automatic t_reset();
    rd_reg(4'h0, s);
    chk("status", s, 32'h9);
    rd_reg(4'h4, s);
    chk("unmapped read", s, 32'h0);
    chk("level", {28'h0, level}, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fill();
    wr_reg(4'h8, 32'h0020, 5);
    for (int i = 0; i < 9; i++) load(32'h8765_4321 + i * 32'h0101_0103);
    chk("full level", {28'h0, level}, 32'h8);
    wr_reg(4'hc, 32'h3, 1);
    for (int i = 0; i < 8; i++) begin
      rx(5, 32'h8765_4321 + i * 32'h0101_0103, 0);
      if (i == 0) chk("start delay", {31'h0, n < 25}, 32'h1);
      if (i > 0) chk("word gap", n, 40);
    end
    rd_reg(4'h0, s);
    chk("status after drain", s, 32'hd);
    wr_reg(4'hc, 32'h2, 1);
    $display("test fill done");
  endtask : t_fill
  task automatic t_parity();
    wr_reg(4'hc, 32'h1, 1);
    load(32'hc5a3_96e1);
    rx(5, 32'hc5a3_96e1, 2);
    wr_reg(4'h8, 32'h1030, 5);
    load(32'h3a5c_691e);
    rx(5, 32'h3a5c_691e, 1);
    wr_reg(4'h8, 32'h2000, 5);
    load(32'hc5a3_96e1);
    rx(40, 32'hc5a3_96e1, 2);
    wr_reg(4'hc, 32'h2, 1);
    $display("test parity done");
  endtask : t_parity
  task automatic t_midreset();
    load(32'h1234_5678);
    chk("level before reset", {28'h0, level}, 32'h1);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(1);
    chk("level after reset", {28'h0, level}, 32'h0);
    rd_reg(4'h0, s);
    chk("status after reset", s, 32'h9);
    $display("test midreset done");
  endtask : t_midreset
  // ====================
  // Run control
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    resetn = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    tick(1);
    t_reset();
    t_fill();
    t_parity();
    t_midreset();
    print_verdict();
  end
endmodule : arinc429_transmitter_fifo_bench
`default_nettype wire
